// >>> pkg/asc_defines.svh
// timing and geometry constants for the async sram host controller
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH
`define ASC_CLK_PERIOD_NS 40
`define ASC_ADDR_W 14
`define ASC_DATA_W 4
`define ASC_DEPTH 16384
// read cycle time, also the recovery time after retention
`define ASC_T_CYCLE_NS 35
// address setup to enable, timed by the setup phase before chip enable falls
`define ASC_T_ADDR_SETUP_NS 5
// write pulse width
`define ASC_T_WP_NS 25
// data setup to end of write
`define ASC_T_DS_NS 12
// enable access time for read sampling
`define ASC_T_ACC_NS 35
// retention entry delay after deselect
`define ASC_T_CDR_NS 0
// power-up settle time in microseconds (2.0 ms)
`define ASC_T_PWRUP_US 2000
`define ASC_CYC_UP(ns) (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_PWRUP_CYC ((`ASC_T_PWRUP_US * 1000) / `ASC_CLK_PERIOD_NS)
`endif

// >>> pkg/asc_pkg.sv
// types for the async sram host controller
package asc_pkg;
   typedef enum logic [2:0] {
      ASC_PWRUP = 3'b000,
      ASC_IDLE = 3'b001,
      ASC_SETUP = 3'b010,
      ASC_ACTIVE = 3'b011,
      ASC_HOLD = 3'b100,
      ASC_RECOVER = 3'b101,
      ASC_RETAIN = 3'b110
   } asc_state_e;
endpackage : asc_pkg

// >>> pkg/asc_timer_if.sv
// load/expire handshake between the sequencer and its interval timer
`timescale 1ns/100ps
interface asc_timer_if;
   logic load;
   logic [15:0] count;
   logic done;
   modport seq (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface : asc_timer_if

// >>> hw/asc_timer.sv
// down counter timing each phase of a memory cycle
`timescale 1ns/100ps
module asc_timer (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   asc_timer_if.tmr tif
);
   logic [15:0] cnt_r;
   // load wins over counting so back-to-back phases never skip a cycle
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_r <= 16'h0000;
      end else if (tif.load) begin
         cnt_r <= tif.count;
      end else if (cnt_r != 16'h0000) begin
         cnt_r <= cnt_r - 16'h0001;
      end
   end
   // done looks only at the count: the sequencer reloads on done, so gating it
   // with load would close a combinational loop through the sequencer
   assign tif.done = (cnt_r == 16'h0000);
endmodule : asc_timer

// >>> hw/asc_host.sv
// host controller driving a 16k x 4 asynchronous static memory
`timescale 1ns/100ps
`include "asc_defines.svh"
module asc_host
   import asc_pkg::*;
#(
   parameter int ADDR_W = `ASC_ADDR_W,
   parameter int DATA_W = `ASC_DATA_W,
   parameter int PWRUP_CYC = `ASC_PWRUP_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_req_valid,
   input wire logic i_req_write,
   input wire logic [ADDR_W-1:0] i_req_addr,
   input wire logic [DATA_W-1:0] i_req_wdata,
   input wire logic i_retain_req,
   output logic o_req_ready,
   output logic o_rd_valid,
   output logic [DATA_W-1:0] o_rd_data,
   output logic o_retained,
   output logic [ADDR_W-1:0] o_addr_lines,
   output logic o_chip_en_n,
   output logic o_write_en_n,
   output logic o_out_en_n,
   input wire logic [DATA_W-1:0] i_data_pins,
   output logic [DATA_W-1:0] o_data_pins,
   output logic [DATA_W-1:0] o_data_pins_oe
);
   localparam logic [15:0] SETUP_CYC = 16'(`ASC_CYC_UP(`ASC_T_ADDR_SETUP_NS));
   localparam logic [15:0] WP_CYC = 16'(`ASC_CYC_UP(`ASC_T_WP_NS));
   localparam logic [15:0] ACC_CYC = 16'(`ASC_CYC_UP(`ASC_T_ACC_NS) + 2);
   localparam logic [15:0] CYCLE_CYC = 16'(`ASC_CYC_UP(`ASC_T_CYCLE_NS));
   localparam logic [15:0] CDR_CYC = 16'(`ASC_CYC_UP(`ASC_T_CDR_NS) + 1);

   asc_state_e state_r;
   logic write_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] wdata_r;
   logic [DATA_W-1:0] din_meta_r;
   logic [DATA_W-1:0] din_sync_r;
   logic [31:0] pwr_cnt_r;
   logic rd_valid_r;
   logic [DATA_W-1:0] rd_data_r;
   logic ce_n_r;
   logic we_n_r;
   logic oe_n_r;
   logic drive_r;
   logic tmr_load;
   logic [15:0] tmr_count;

   asc_timer_if tif ();
   asc_timer u_timer (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .tif(tif)
   );
   assign tif.load = tmr_load;
   assign tif.count = tmr_count;

   // data pins come from outside the clock domain: two flops first
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         din_meta_r <= '0;
         din_sync_r <= '0;
      end else begin
         din_meta_r <= i_data_pins;
         din_sync_r <= din_meta_r;
      end
   end

   // power-up hold-off counter
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         pwr_cnt_r <= 32'h0000_0000;
      end else if (state_r == ASC_PWRUP && pwr_cnt_r != 32'(PWRUP_CYC)) begin
         pwr_cnt_r <= pwr_cnt_r + 32'h0000_0001;
      end
   end

   // ready only in idle, so a request is accepted exactly once
   assign o_req_ready = (state_r == ASC_IDLE) && !i_retain_req;

   // phase sequencer; entering setup, active, retain or recover reloads the timer
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         state_r <= ASC_PWRUP;
      end else begin
         unique case (state_r)
            ASC_PWRUP: begin
               if (pwr_cnt_r == 32'(PWRUP_CYC)) state_r <= ASC_IDLE;
            end
            ASC_IDLE: begin
               if (i_retain_req) state_r <= ASC_RETAIN;
               else if (i_req_valid) state_r <= ASC_SETUP;
            end
            ASC_SETUP: begin
               if (tif.done) state_r <= ASC_ACTIVE;
            end
            ASC_ACTIVE: begin
               if (tif.done) state_r <= ASC_HOLD;
            end
            ASC_HOLD: begin
               state_r <= ASC_IDLE;
            end
            ASC_RETAIN: begin
               if (!i_retain_req && tif.done) state_r <= ASC_RECOVER;
            end
            ASC_RECOVER: begin
               if (tif.done) state_r <= ASC_IDLE;
            end
            default: state_r <= ASC_IDLE;
         endcase
      end
   end

   // timer load values per phase entry
   always_comb begin
      tmr_load = 1'b0;
      tmr_count = 16'h0000;
      if (state_r == ASC_IDLE && i_retain_req) begin
         tmr_load = 1'b1;
         tmr_count = CDR_CYC;
      end else if (state_r == ASC_IDLE && i_req_valid) begin
         tmr_load = 1'b1;
         tmr_count = SETUP_CYC;
      end else if (state_r == ASC_SETUP && tif.done) begin
         tmr_load = 1'b1;
         tmr_count = write_r ? WP_CYC : ACC_CYC;
      end else if (state_r == ASC_RETAIN && !i_retain_req && tif.done) begin
         tmr_load = 1'b1;
         tmr_count = CYCLE_CYC;
      end
   end

   // capture request; address and data stay put until the next request
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         write_r <= 1'b0;
         addr_r <= '0;
         wdata_r <= '0;
      end else if (state_r == ASC_IDLE && i_req_valid && !i_retain_req) begin
         write_r <= i_req_write;
         addr_r <= i_req_addr;
         wdata_r <= i_req_wdata;
      end
   end

   // memory control pins, all registered so no glitch reaches the device
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         ce_n_r <= 1'b1;
         we_n_r <= 1'b1;
         oe_n_r <= 1'b1;
         drive_r <= 1'b0;
      end else begin
         unique case (state_r)
            ASC_SETUP: begin
               ce_n_r <= 1'b1;
               we_n_r <= ~write_r;
               oe_n_r <= 1'b1;
               drive_r <= write_r;
               if (tif.done) ce_n_r <= 1'b0;
            end
            ASC_ACTIVE: begin
               oe_n_r <= write_r;
               if (tif.done) ce_n_r <= 1'b1;
            end
            ASC_HOLD: begin
               // chip enable rose first; write enable and data follow
               we_n_r <= 1'b1;
               oe_n_r <= 1'b1;
               drive_r <= 1'b0;
            end
            default: begin
               ce_n_r <= 1'b1;
               we_n_r <= 1'b1;
               oe_n_r <= 1'b1;
               drive_r <= 1'b0;
            end
         endcase
      end
   end

   assign o_chip_en_n = ce_n_r;
   assign o_write_en_n = we_n_r;
   assign o_out_en_n = oe_n_r;
   assign o_addr_lines = addr_r;
   assign o_data_pins = wdata_r;
   assign o_data_pins_oe = {DATA_W{drive_r}};

   // read data sampled from synchronised pins at end of access window
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         rd_valid_r <= 1'b0;
         rd_data_r <= '0;
      end else begin
         rd_valid_r <= 1'b0;
         if (state_r == ASC_ACTIVE && !write_r && tif.done) begin
            rd_valid_r <= 1'b1;
            rd_data_r <= din_sync_r;
         end
      end
   end

   assign o_rd_valid = rd_valid_r;
   assign o_rd_data = rd_data_r;
   assign o_retained = (state_r == ASC_RETAIN);
endmodule : asc_host

// >>> verification/asc_sram_model.sv
// behavioural 16k x 4 asynchronous static memory facing the host
`timescale 1ns/100ps
module asc_sram_model (
   input wire logic [13:0] i_addr_lines,
   input wire logic i_chip_en_n,
   input wire logic i_write_en_n,
   input wire logic i_out_en_n,
   input wire logic [3:0] i_data_pins,
   output logic [3:0] o_data_pins,
   output logic o_drive
);
   logic [3:0] mem [0:16383];
   logic [3:0] last_r = 4'h0;
   // level write over the enable overlap: the word seen before either rise sticks
   always @* begin
      if (!i_chip_en_n && !i_write_en_n) mem[i_addr_lines] = i_data_pins;
   end
   assign o_drive = !i_chip_en_n && i_write_en_n && !i_out_en_n;
   // remember the last word driven
   always @* begin
      if (o_drive) last_r = mem[i_addr_lines];
   end
   // a released bus shows the inverse word, so a stale sample cannot pass
   assign o_data_pins = o_drive ? mem[i_addr_lines] : ~last_r;
endmodule : asc_sram_model

// >>> verification/asc_host_monitor.sv
// concurrent checks on the sram host controller ports
`timescale 1ns/100ps
module asc_host_monitor #(
   parameter int ADDR_W = 14,
   parameter int DATA_W = 4,
   parameter int PWRUP_CYC = 50000
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_retain_req,
   input wire logic o_req_ready,
   input wire logic o_rd_valid,
   input wire logic o_retained,
   input wire logic [ADDR_W-1:0] o_addr_lines,
   input wire logic o_chip_en_n,
   input wire logic o_write_en_n,
   input wire logic o_out_en_n,
   input wire logic [DATA_W-1:0] o_data_pins,
   input wire logic [DATA_W-1:0] o_data_pins_oe
);
   logic [15:0] up_cnt_r;
   // edges since reset left; saturates so a long run cannot wrap it
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) up_cnt_r <= 16'h0000;
      else if (up_cnt_r != 16'hffff) up_cnt_r <= up_cnt_r + 16'h0001;
   end
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rstn);
   sequence s_no_drive;
      o_data_pins_oe == '0;
   endsequence
   sequence s_write_end;
      $rose(o_chip_en_n) && !o_write_en_n;
   endsequence
   chk_write_oe_off: assert property (!o_write_en_n |-> o_out_en_n)
      else $error("write with output enable on");
   chk_read_float: assert property (!o_out_en_n |-> s_no_drive)
      else $error("pins driven while memory outputs on");
   chk_we_leads: assert property ($fell(o_write_en_n) |-> o_chip_en_n && o_out_en_n)
      else $error("write enable fell after chip enable");
   chk_addr_stable: assert property (!o_chip_en_n |-> $stable(o_addr_lines))
      else $error("address moved while selected");
   chk_write_hold: assert property (s_write_end |-> $stable(o_data_pins) && (&o_data_pins_oe))
      else $error("write data not held at end of write");
   chk_pwrup_wait: assert property ((o_req_ready || !o_chip_en_n) |-> up_cnt_r >= PWRUP_CYC)
      else $error("access before power-up wait");
   chk_retain_desel: assert property (o_retained |-> o_chip_en_n && !o_req_ready)
      else $error("selected during retention");
   chk_retain_recov: assert property ($fell(o_retained) |-> !o_req_ready ##1 o_chip_en_n)
      else $error("access without recovery");
   chk_rd_pulse: assert property (o_rd_valid |-> s_no_drive ##1 !o_rd_valid)
      else $error("read valid not a single pulse");
   chk_ready_idle: assert property (o_req_ready |-> !i_retain_req && o_chip_en_n)
      else $error("ready while busy or retaining");
endmodule : asc_host_monitor

// >>> verification/asc_host_tb_top.sv
// self-checking bench for the sram host controller
`timescale 1ns/100ps
module asc_host_tb_top;
   localparam int PW = 20;
   logic clk = 1'b0, rstn = 1'b0, vld = 1'b0, wr = 1'b0, ret = 1'b0;
   logic [13:0] addr = 14'h0000, a_l;
   logic [3:0] wd = 4'h0, rd, h_q, h_oe, m_q, pins_w;
   logic rdy, rv, rtd, ce_n, we_n, oe_n, m_drv;
   int miscompares = 0;
   int n_compared = 0;
   // the host wins the wire only while driving; otherwise the memory's view
   assign pins_w = (&h_oe) ? h_q : m_q;
   asc_host #(.PWRUP_CYC(PW)) u_dut (.i_clk_sys(clk), .i_rstn(rstn), .i_req_valid(vld),
      .i_req_write(wr), .i_req_addr(addr), .i_req_wdata(wd), .i_retain_req(ret),
      .o_req_ready(rdy), .o_rd_valid(rv), .o_rd_data(rd), .o_retained(rtd), .o_addr_lines(a_l),
      .o_chip_en_n(ce_n), .o_write_en_n(we_n), .o_out_en_n(oe_n), .i_data_pins(pins_w),
      .o_data_pins(h_q), .o_data_pins_oe(h_oe));
   asc_sram_model u_mem (.i_addr_lines(a_l), .i_chip_en_n(ce_n), .i_write_en_n(we_n),
      .i_out_en_n(oe_n), .i_data_pins(pins_w), .o_data_pins(m_q), .o_drive(m_drv));
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   // one request held until taken; reads wait for the answer pulse
   task automatic do_req(input logic w, input logic [13:0] a, input logic [3:0] d,
      output logic [3:0] q);
      int n;
      n = 0;
      vld <= 1'b1;
      wr <= w;
      addr <= a;
      wd <= d;
      @(posedge clk);
      while (rdy !== 1'b1 && n < 300) begin
         n++;
         @(posedge clk);
      end
      vld <= 1'b0;
      @(posedge clk);
      while (!w && rv !== 1'b1 && n < 300) begin
         n++;
         @(posedge clk);
      end
      q = rd;
      if (n >= 300) miscompares++;
   endtask : do_req
   task automatic t_pwrup();
      int n;
      n = 0;
      while (rdy !== 1'b1 && n < 100) begin
         n++;
         @(posedge clk);
      end
      check("power-up wait", 4'h1, {3'h0, n >= PW && n < 100});
   endtask : t_pwrup
   task automatic t_rw();
      logic [13:0] a [4];
      logic [3:0] q;
      a = '{14'h0000, 14'h0001, 14'h2aaa, 14'h3fff};
      for (int i = 0; i < 4; i++) do_req(1'b1, a[i], a[i][3:0] ^ 4'h5, q);
      for (int i = 0; i < 4; i++) begin
         do_req(1'b0, a[i], 4'h0, q);
         check("read word", a[i][3:0] ^ 4'h5, q);
      end
   endtask : t_rw
   task automatic t_retain();
      logic [3:0] q;
      int n;
      n = 0;
      ret <= 1'b1;
      repeat (4) @(posedge clk);
      check("retained", 4'h1, {3'h0, rtd});
      check("deselected", 4'h1, {3'h0, ce_n});
      ret <= 1'b0;
      @(posedge clk);
      while (rdy !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      check("recovery wait", 4'h1, {3'h0, n >= 2 && n < 20});
      do_req(1'b0, 14'h3fff, 4'h0, q);
      check("kept word", 4'ha, q);
   endtask : t_retain
   // both sides driving the wire at once is bus contention
   always @(posedge clk) begin
      if (|h_oe && m_drv) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", "contention", 1'b0, 1'b1);
      end
   end
   initial begin
      logic [3:0] q;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_pwrup();
      t_rw();
      t_retain();
      // a second reset must not touch stored words
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_pwrup();
      do_req(1'b0, 14'h0001, 4'h0, q);
      check("word after reset", 4'h4, q);
      stop_test();
   end
   // cut a hang short well past the expected few hundred cycles
   initial begin
      #200000;
      miscompares++;
      stop_test();
   end
endmodule : asc_host_tb_top
bind asc_host asc_host_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .PWRUP_CYC(PWRUP_CYC))
   u_mon (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_retain_req(i_retain_req),
   .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .o_retained(o_retained),
   .o_addr_lines(o_addr_lines), .o_chip_en_n(o_chip_en_n), .o_write_en_n(o_write_en_n),
   .o_out_en_n(o_out_en_n), .o_data_pins(o_data_pins), .o_data_pins_oe(o_data_pins_oe));
